// >>> i2ce_err_top.v
// error detection, flag, interrupt and request logic of a two-wire bus controller
// assumes the transfer sequencer beside it runs on clk and reports with pulses;
// bus pins arrive asynchronously and are synchronised here
`timescale 1ns/100ps
`include "i2ce_defines.vh"

module i2ce_err_top (
  // clock and reset
  input  wire        clk,
  input  wire        nrst,
  // avalon-mm slave
  input  wire [4:0]  avsAddress,
  input  wire        avsRead,
  input  wire        avsWrite,
  input  wire [31:0] avsWritedata,
  output reg  [31:0] avsReaddata,
  output reg         avsWaitrequest,
  // bus pins, observed only
  input  wire        sclPin,
  input  wire        sdaPin,
  input  wire        alertLinePin,
  // status from the transfer sequencer
  input  wire        coreMaster,
  input  wire        coreSlaveAddressed,
  input  wire        coreAddrPhase,
  input  wire        coreSdaReleased,
  input  wire        coreStretching,
  input  wire        coreRxValid,
  input  wire [7:0]  coreRxByte,
  input  wire        coreRxIsPec,
  input  wire [7:0]  corePecValue,
  input  wire        coreTxNeed,
  input  wire        coreTxFirst,
  input  wire        coreStartDone,
  input  wire        coreReloadPause,
  input  wire        coreTransferDone,
  input  wire        coreNackSeen,
  input  wire        coreAddrMatch,
  // system state
  input  wire        stopMode,
  input  wire        kernelOnInternalOsc,
  input  wire        debugHalt,
  input  wire        debugTimeoutFreeze,
  // actions toward the sequencer
  output reg  [7:0]  txByte,
  output reg         txByteValid,
  output reg         nackRequest,
  output reg         releaseBus,
  output reg         toSlaveMode,
  output reg         stopRequest,
  output reg         startRequest,
  output reg         addrRecognize,
  output reg         wakeupRequest,
  // dma and interrupt lines
  output reg         txDmaReq,
  output reg         rxDmaReq,
  output reg         eventIrq,
  output reg         errorIrq
);

  localparam integer TICK_N    = (`I2CE_TICK_NS * `I2CE_CLK_MHZ) / 1000;
  localparam [7:0]   TICK_LAST = TICK_N[7:0] - 8'h01;

  reg  [`I2CE_CTL_WIDTH-1:0] ctrl_q;
  reg  [31:0]                to_q;
  reg  [7:0]                 byteCount_q;
  reg  [7:0]                 rxData_q;
  reg  [7:0]                 txData_q;
  reg                        txEmpty_q;
  reg  [`I2CE_F_WIDTH-1:0]   flags_q;
  reg  [`I2CE_F_WIDTH-1:0]   setV;
  reg  [`I2CE_F_WIDTH-1:0]   clrV;
  reg  [31:0]                rdMux;
  reg                        sclPrev_q;
  reg                        sdaPrev_q;
  reg                        alPrev_q;
  reg  [3:0]                 bitCnt_q;
  reg                        busBusy_q;
  reg  [7:0]                 tickCnt_q;
  reg  [11:0]                toA_q;
  reg  [11:0]                toB_q;
  wire [2:0]                 pinS;
  wire                       sclS;
  wire                       sdaS;
  wire                       alS;

  i2ce_sync #(
    .W    (3)
  ) uSync (
    .clk  (clk),
    .nrst (nrst),
    .din  ({alertLinePin, sdaPin, sclPin}),
    .dout (pinS)
  );

  assign sclS = pinS[0];
  assign sdaS = pinS[1];
  assign alS  = pinS[2];

  // bus access: one wait cycle, then the access completes
  wire rdAcc  = avsRead & ~avsWaitrequest;
  wire wrAcc  = avsWrite & ~avsWaitrequest;
  wire wrCtl  = wrAcc & (avsAddress == `I2CE_OFF_CTRL);
  wire wrCtl2 = wrAcc & (avsAddress == `I2CE_OFF_CTRL2);
  wire wrClr  = wrAcc & (avsAddress == `I2CE_OFF_CLEAR);
  wire wrTo   = wrAcc & (avsAddress == `I2CE_OFF_TIMEOUT);
  wire wrTx   = wrAcc & (avsAddress == `I2CE_OFF_TXDATA);
  wire rdRx   = rdAcc & (avsAddress == `I2CE_OFF_RXDATA);

  // control aliases
  wire enable   = ctrl_q[`I2CE_CTL_ENABLE];
  wire holdDis  = ctrl_q[`I2CE_CTL_HOLDDIS];
  wire idleSel  = ctrl_q[`I2CE_CTL_IDLESEL];
  wire [11:0] firstPeriod = to_q[11:0];
  wire [11:0] cumPeriod   = to_q[27:16];

  // line conditions seen on the synchronised pins
  wire sclRise   = sclS & ~sclPrev_q;
  wire startCond = sclS & sclPrev_q & sdaPrev_q & ~sdaS;
  wire stopCond  = sclS & sclPrev_q & ~sdaPrev_q & sdaS;
  wire involved  = coreMaster | (coreSlaveAddressed & ~coreAddrPhase);
  wire slaveNs   = holdDis & ~coreMaster;

  wire misplaced = (startCond | stopCond) & busBusy_q & (bitCnt_q != 4'h0);
  // ignored unless taking part past address
  wire berrSet   = misplaced & involved;
  // released high but low at rising scl
  wire arbSet    = sclRise & coreSdaReleased & ~sdaS & involved;

  // halt may freeze the timeout counters
  wire runTo  = enable & ~(debugHalt & debugTimeoutFreeze);
  wire tick   = (tickCnt_q == TICK_LAST);
  // low or idle lines, selected by idle detect
  wire condA  = idleSel ? (sclS & sdaS) : ~sclS;
  wire hitA   = to_q[`I2CE_TO_ENA] & condA & tick & runTo
                & (toA_q == firstPeriod - 12'h001) & (firstPeriod != 12'h000);
  wire hitB   = to_q[`I2CE_TO_ENB] & coreStretching & tick & runTo
                & (toB_q == cumPeriod - 12'h001) & (cumPeriod != 12'h000);
  wire toHit  = hitA | hitB;

  // transmit underrun when the slave cannot hold the clock
  wire ovrTx  = coreTxNeed & slaveNs & (txEmpty_q | (coreTxFirst & flags_q[`I2CE_F_STOP]));
  // receive overrun while the previous byte is unread
  wire ovrRx  = coreRxValid & slaveNs & flags_q[`I2CE_F_RECEIVE_NOT_EMPTY_FLAG];
  wire pecBad = coreRxValid & ~ovrRx & coreRxIsPec & (coreRxByte != corePecValue);
  wire alFall = alPrev_q & ~alS & ctrl_q[`I2CE_CTL_HOSTROLE] & ctrl_q[`I2CE_CTL_ALERT_PIN_ENABLE];

  // flag set and clear vectors
  always @* begin
    setV = {`I2CE_F_WIDTH{1'b0}};
    setV[`I2CE_F_RECEIVE_NOT_EMPTY_FLAG]    = coreRxValid & ~ovrRx;
    setV[`I2CE_F_TRANSMIT_INTERRUPT_STATUS]    = coreTxNeed;
    setV[`I2CE_F_STOP]    = stopCond;
    setV[`I2CE_F_RELOAD]  = coreReloadPause;
    setV[`I2CE_F_TC]      = coreTransferDone;
    setV[`I2CE_F_NACK]    = coreNackSeen;
    setV[`I2CE_F_ADDR]    = coreAddrMatch;
    setV[`I2CE_F_MISPLACED_CONDITION_FLAG]    = berrSet;
    setV[`I2CE_F_ARB]     = arbSet;
    setV[`I2CE_F_OVR]     = ovrRx | ovrTx;
    setV[`I2CE_F_PEC]     = pecBad;
    setV[`I2CE_F_TIMEOUT] = toHit;
    setV[`I2CE_F_ALERT]   = alFall;
    clrV = wrClr ? (avsWritedata[`I2CE_F_WIDTH-1:0] & `I2CE_CLR_MASK)
                 : {`I2CE_F_WIDTH{1'b0}};
    clrV[`I2CE_F_RECEIVE_NOT_EMPTY_FLAG]   = rdRx;
    clrV[`I2CE_F_TRANSMIT_INTERRUPT_STATUS]   = wrTx;
    clrV[`I2CE_F_RELOAD] = wrCtl2 & (avsWritedata[7:0] != 8'h00);
    clrV[`I2CE_F_TC]     = wrCtl2 & (avsWritedata[`I2CE_CT2_START]
                                     | avsWritedata[`I2CE_CT2_STOP]);
  end

  // read data selection; unmapped offsets read zero
  always @* begin
    case (avsAddress)
      `I2CE_OFF_CTRL:    rdMux = {20'h00000, ctrl_q};
      `I2CE_OFF_CTRL2:   rdMux = {22'h000000, stopRequest, startRequest, byteCount_q};
      `I2CE_OFF_STATUS:  rdMux = {17'h00000, busBusy_q, txEmpty_q, flags_q};
      `I2CE_OFF_TIMEOUT: rdMux = to_q;
      `I2CE_OFF_RXDATA:  rdMux = {24'h000000, rxData_q};
      `I2CE_OFF_PEC:     rdMux = {24'h000000, corePecValue};
      default:           rdMux = 32'h00000000;
    endcase
  end

  // bus handshake: waitrequest drops one cycle after the request
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      avsWaitrequest <= 1'b1;
      avsReaddata    <= 32'h00000000;
    end else if (avsWaitrequest) begin
      if (avsRead | avsWrite) begin
        avsWaitrequest <= 1'b0;
        avsReaddata    <= rdMux;
      end
    end else begin
      avsWaitrequest <= 1'b1;
    end
  end

  // software registers
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_q      <= `I2CE_CTL_RESET;
      to_q        <= `I2CE_TO_RESET;
      byteCount_q <= 8'h00;
      txData_q    <= 8'h00;
    end else begin
      if (wrCtl) ctrl_q <= avsWritedata[`I2CE_CTL_WIDTH-1:0];
      if (wrTo) to_q <= avsWritedata;
      if (wrCtl2) byteCount_q <= avsWritedata[7:0];
      if (wrTx) txData_q <= avsWritedata[7:0];
    end
  end

  // sticky flags, set wins over clear
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      flags_q <= {`I2CE_F_WIDTH{1'b0}};
    end else begin
      flags_q <= (flags_q & ~clrV) | setV;
    end
  end

  // pin history, bit position and busy state
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sclPrev_q <= 1'b1;
      sdaPrev_q <= 1'b1;
      alPrev_q  <= 1'b1;
      bitCnt_q  <= 4'h0;
      busBusy_q <= 1'b0;
    end else begin
      sclPrev_q <= sclS;
      sdaPrev_q <= sdaS;
      alPrev_q  <= alS;
      if (startCond | stopCond) begin
        bitCnt_q <= 4'h0;
      end else if (sclRise) begin
        bitCnt_q <= (bitCnt_q == `I2CE_BITS_FRAME) ? 4'h0 : bitCnt_q + 4'h1;
      end
      if (startCond) begin
        busBusy_q <= 1'b1;
      end else if (stopCond) begin
        busBusy_q <= 1'b0;
      end
    end
  end

  // timeout prescaler and the two period counters
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tickCnt_q <= 8'h00;
      toA_q     <= 12'h000;
      toB_q     <= 12'h000;
    end else begin
      tickCnt_q <= tick ? 8'h00 : tickCnt_q + 8'h01;
      // restart whenever the watched condition breaks
      if (!condA) begin
        toA_q <= 12'h000;
      end else if (tick & runTo & (toA_q != firstPeriod)) begin
        toA_q <= toA_q + 12'h001;
      end
      // accumulates across stretches until a frame boundary
      if (startCond | stopCond) begin
        toB_q <= 12'h000;
      end else if (coreStretching & tick & runTo & (toB_q != cumPeriod)) begin
        toB_q <= toB_q + 12'h001;
      end
    end
  end

  // received bytes and transmit register state
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rxData_q  <= 8'h00;
      txEmpty_q <= 1'b1;
    end else begin
      if (coreRxValid & ~ovrRx) rxData_q <= coreRxByte;
      // a write beside a need refills after the old byte goes
      if (wrTx) begin
        txEmpty_q <= 1'b0;
      end else if (coreTxNeed) begin
        txEmpty_q <= 1'b1;
      end
    end
  end

  // actions toward the sequencer, mostly one-cycle pulses
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      txByte        <= 8'h00;
      txByteValid   <= 1'b0;
      nackRequest   <= 1'b0;
      releaseBus    <= 1'b0;
      toSlaveMode   <= 1'b0;
      stopRequest   <= 1'b0;
      startRequest  <= 1'b0;
      addrRecognize <= 1'b0;
      wakeupRequest <= 1'b0;
    end else begin
      txByteValid <= coreTxNeed;
      // first byte after stop: data if loaded, else fill
      if (coreTxNeed) txByte <= txEmpty_q ? `I2CE_FILL_BYTE : txData_q;
      nackRequest <= ovrRx | pecBad;
      // master loss releases lines; slave aborts
      releaseBus <= arbSet | (toHit & ~coreMaster);
      // master loss falls back to slave
      toSlaveMode <= arbSet & coreMaster;
      // any start seen while not master, even misplaced, restarts recognition
      addrRecognize <= startCond & ~coreMaster;
      // match wakes only with wake-up and internal oscillator
      wakeupRequest <= stopMode & ctrl_q[`I2CE_CTL_WAKEEN] & kernelOnInternalOsc
                       & coreAddrMatch;
      if (wrCtl2 & avsWritedata[`I2CE_CT2_STOP]) begin
        stopRequest <= 1'b1;
      end else if (toHit & coreMaster) begin
        stopRequest <= 1'b1;
      end else if (stopCond) begin
        stopRequest <= 1'b0;
      end
      // start cleared by loss, also by timeout
      if (coreStartDone | (arbSet & coreMaster) | toHit) begin
        startRequest <= 1'b0;
      end else if (wrCtl2 & avsWritedata[`I2CE_CT2_START]) begin
        startRequest <= 1'b1;
      end
    end
  end

  // dma requests and interrupt lines, registered levels
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      txDmaReq <= 1'b0;
      rxDmaReq <= 1'b0;
      eventIrq <= 1'b0;
      errorIrq <= 1'b0;
    end else begin
      txDmaReq <= ctrl_q[`I2CE_CTL_TXREQEN] & flags_q[`I2CE_F_TRANSMIT_INTERRUPT_STATUS];
      rxDmaReq <= ctrl_q[`I2CE_CTL_RXREQEN] & flags_q[`I2CE_F_RECEIVE_NOT_EMPTY_FLAG];
      // event line from flags and enables
      eventIrq <= (ctrl_q[`I2CE_CTL_RECEIVE_IRQ_ENABLE] & flags_q[`I2CE_F_RECEIVE_NOT_EMPTY_FLAG])
                | (ctrl_q[`I2CE_CTL_TRANSMIT_IRQ_ENABLE] & flags_q[`I2CE_F_TRANSMIT_INTERRUPT_STATUS])
                | (ctrl_q[`I2CE_CTL_EVIE] & (|flags_q[`I2CE_F_ADDR:`I2CE_F_STOP]));
      errorIrq <= ctrl_q[`I2CE_CTL_ERROR_IRQ_ENABLE] & (|(flags_q & `I2CE_ERR_MASK));
    end
  end

endmodule // i2ce_err_top

// >>> i2ce_defines.vh
// constants for the two-wire error, flag and request logic
// assumes a 100 MHz system clock and a word-aligned Avalon-MM slave
`ifndef I2CE_DEFINES_VH
`define I2CE_DEFINES_VH

// register byte offsets
`define I2CE_OFF_CTRL    5'h00
`define I2CE_OFF_CTRL2   5'h04
`define I2CE_OFF_STATUS  5'h08
`define I2CE_OFF_CLEAR   5'h0c
`define I2CE_OFF_TIMEOUT 5'h10
`define I2CE_OFF_RXDATA  5'h14
`define I2CE_OFF_TXDATA  5'h18
`define I2CE_OFF_PEC     5'h1c

// control register one fields
`define I2CE_CTL_ENABLE    0
`define I2CE_CTL_ERROR_IRQ_ENABLE     1
`define I2CE_CTL_TRANSMIT_IRQ_ENABLE      2
`define I2CE_CTL_RECEIVE_IRQ_ENABLE      3
`define I2CE_CTL_EVIE      4
`define I2CE_CTL_TXREQEN   5
`define I2CE_CTL_RXREQEN   6
`define I2CE_CTL_HOLDDIS   7
`define I2CE_CTL_IDLESEL   8
`define I2CE_CTL_HOSTROLE  9
`define I2CE_CTL_ALERT_PIN_ENABLE   10
`define I2CE_CTL_WAKEEN    11
`define I2CE_CTL_WIDTH     12
`define I2CE_CTL_RESET     12'h000

// control register two fields
`define I2CE_CT2_START     8
`define I2CE_CT2_STOP      9

// timeout register fields
`define I2CE_TO_ENA        15
`define I2CE_TO_ENB        31
`define I2CE_TO_RESET      32'h00000000

// status / clear bit positions
`define I2CE_F_RECEIVE_NOT_EMPTY_FLAG     0
`define I2CE_F_TRANSMIT_INTERRUPT_STATUS     1
`define I2CE_F_STOP     2
`define I2CE_F_RELOAD   3
`define I2CE_F_TC       4
`define I2CE_F_NACK     5
`define I2CE_F_ADDR     6
`define I2CE_F_MISPLACED_CONDITION_FLAG     7
`define I2CE_F_ARB      8
`define I2CE_F_OVR      9
`define I2CE_F_PEC      10
`define I2CE_F_TIMEOUT  11
`define I2CE_F_ALERT    12
`define I2CE_F_WIDTH    13
`define I2CE_F_TXE      13
`define I2CE_F_BUSY     14
`define I2CE_ERR_MASK   13'h1f80
`define I2CE_CLR_MASK   13'h1fe4

// timing
`define I2CE_CLK_MHZ    100
`define I2CE_TICK_NS    160
`define I2CE_BITS_FRAME 4'h8
`define I2CE_FILL_BYTE  8'hff

`endif

// >>> i2ce_sync.v
// two-flop synchroniser for a group of asynchronous levels
// assumes inputs are quasi-static relative to clk
`timescale 1ns/100ps

module i2ce_sync #(
  parameter W = 1
) (
  // clock and reset
  input  wire         clk,
  input  wire         nrst,
  // levels
  input  wire [W-1:0] din,
  output reg  [W-1:0] dout
);

  reg [W-1:0] meta_q;

  // first stage feeds only the second; reset to bus idle high
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_q <= {W{1'b1}};
      dout   <= {W{1'b1}};
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end

endmodule // i2ce_sync

// >>> i2ce_err_chk.sv
// concurrent checks on the ports of the two-wire error logic
// assumes it is bound to i2ce_err_top and sees that module's ports only
`timescale 1ns/100ps

module i2ce_err_chk (
  // clock and reset
  input wire        clk,
  input wire        nrst,
  // register bus
  input wire [4:0]  avsAddress,
  input wire        avsRead,
  input wire        avsWrite,
  input wire [31:0] avsReaddata,
  input wire        avsWaitrequest,
  // sequencer and system side
  input wire        coreRxValid,
  input wire        coreTxNeed,
  input wire        coreAddrMatch,
  input wire        stopMode,
  input wire        kernelOnInternalOsc,
  // actions and lines
  input wire [7:0]  txByte,
  input wire        txByteValid,
  input wire        nackRequest,
  input wire        releaseBus,
  input wire        toSlaveMode,
  input wire        startRequest,
  input wire        wakeupRequest,
  input wire        rxDmaReq,
  input wire        errorIrq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // access completes at the edge that sees waitrequest low
  wire acc = (avsRead || avsWrite) && !avsWaitrequest;

  a_wait_one: assert property ((avsRead || avsWrite) && avsWaitrequest |=> !avsWaitrequest)
    else $error("access not answered after one wait cycle");
  a_wait_idle: assert property (!(avsRead || avsWrite) |=> avsWaitrequest)
    else $error("waitrequest low without a request");
  a_unmapped_zero: assert property (acc && avsRead && avsAddress > 5'h1c |-> avsReaddata == 32'h0)
    else $error("unmapped read not zero");
  a_tx_answer: assert property (coreTxNeed |=> txByteValid)
    else $error("no byte offered after a send request");
  a_nack_cause: assert property (nackRequest |-> $past(coreRxValid))
    else $error("nack without a received byte");
  a_wake_cause: assert property (wakeupRequest |-> $past(stopMode && kernelOnInternalOsc && coreAddrMatch))
    else $error("wakeup without match in stop mode");
  a_arb_release: assert property (toSlaveMode |-> ##[0:1] releaseBus)
    else $error("lines kept after lost arbitration");
  a_arb_start: assert property (toSlaveMode |=> !startRequest)
    else $error("start kept after lost arbitration");
  a_err_fall: assert property ($fell(errorIrq) |-> $past(avsWrite && !avsWaitrequest, 2))
    else $error("error line dropped without a write");
  a_rx_clear: assert property (acc && avsRead && avsAddress == 5'h14 |-> ##2 !rxDmaReq)
    else $error("receive request kept after data read");

  // main scenarios seen
  c_err_irq: cover property ($rose(errorIrq));
  c_fill: cover property (txByteValid && txByte == 8'hff);
  c_wake: cover property (wakeupRequest);
endmodule // i2ce_err_chk

bind i2ce_err_top i2ce_err_chk i2ce_err_chk_inst (.clk, .nrst, .avsAddress, .avsRead,
  .avsWrite, .avsReaddata, .avsWaitrequest, .coreRxValid, .coreTxNeed, .coreAddrMatch,
  .stopMode, .kernelOnInternalOsc, .txByte, .txByteValid, .nackRequest, .releaseBus,
  .toSlaveMode, .startRequest, .wakeupRequest, .rxDmaReq, .errorIrq);

// >>> i2ce_bus_model.sv
// other parties on the two-wire bus, driving the lines the block observes
// assumes pull-ups: lines idle high, clock stands still between frames
`timescale 1ns/100ps

module i2ce_bus_model (
  // bus lines
  output reg scl,
  output reg sda,
  output reg alertLine
);
  // idle bus
  initial begin
    scl = 1'b1;
    sda = 1'b1;
    alertLine = 1'b1;
  end
  // start or stop: sda edge while scl high
  task cond(input bit rise);
    begin
      sda = rise;
      #80;
    end
  endtask
  // n clock pulses of 160 ns, sda set in the low phase, scl left high
  task pulses(input integer n, input bit last);
    integer i;
    begin
      for (i = 0; i < n; i = i + 1) begin
        scl = 1'b0;
        #40 sda = (i == n - 1) ? last : 1'b1;
        #40 scl = 1'b1;
        #80;
      end
    end
  endtask
  // clock held low by another party
  task lowFor(input integer ns);
    begin
      scl = 1'b0;
      #(ns) scl = 1'b1;
    end
  endtask
  task alert;
    begin
      alertLine = 1'b0;
      #160 alertLine = 1'b1;
    end
  endtask
endmodule // i2ce_bus_model

// >>> i2ce_err_top_tb.sv
// self-checking bench for the two-wire error, flag and request logic
// assumes the bus model and the bound checker are compiled alongside
`timescale 1ns/100ps
`include "i2ce_defines.vh"

module i2ce_err_top_tb;
  // design inputs and outputs
  reg         clk = 1'b0, nrst = 1'b0, avsRead = 1'b0, avsWrite = 1'b0;
  reg  [4:0]  avsAddress = 5'h00;
  reg  [31:0] avsWritedata = 32'h0, rdata;
  wire [31:0] avsReaddata;
  wire        avsWaitrequest, sclPin, sdaPin, alertLinePin;
  reg         coreMaster = 1'b0, coreSlaveAddressed = 1'b0, coreSdaReleased = 1'b0;
  reg         coreRxValid = 1'b0, coreRxIsPec = 1'b0, coreTxNeed = 1'b0, coreStartDone = 1'b0;
  reg         coreAddrMatch = 1'b0, stopMode = 1'b0, kernelOnInternalOsc = 1'b0;
  reg         debugHalt = 1'b0, debugTimeoutFreeze = 1'b0;
  reg         coreAddrPhase = 1'b0, coreStretching = 1'b0, coreTxFirst = 1'b0;
  reg         coreReloadPause = 1'b0, coreTransferDone = 1'b0, coreNackSeen = 1'b0;
  reg  [7:0]  coreRxByte = 8'h00, corePecValue = 8'h3c;
  wire [7:0]  txByte;
  wire        txByteValid, nackRequest, releaseBus, toSlaveMode, stopRequest, startRequest;
  wire        addrRecognize, wakeupRequest, txDmaReq, rxDmaReq, eventIrq, errorIrq;
  integer     n_errors = 0, n_compared = 0, nNack = 0, nRel = 0, nAddr = 0, nWake = 0, h;

  always #5 clk = ~clk;

  // pulse outputs tallied, so no pulse is missed between checks
  always @(posedge clk) begin
    nNack <= nNack + nackRequest;
    nRel <= nRel + releaseBus;
    nAddr <= nAddr + addrRecognize;
    nWake <= nWake + wakeupRequest;
  end

  // every sequencer input but the constant corePecValue is driven by some scenario
  i2ce_err_top i2ce_err_top_inst (.clk, .nrst, .avsAddress, .avsRead, .avsWrite,
    .avsWritedata, .avsReaddata, .avsWaitrequest, .sclPin, .sdaPin, .alertLinePin,
    .coreMaster, .coreSlaveAddressed, .coreAddrPhase,
    .coreSdaReleased, .coreStretching, .coreRxValid, .coreRxByte, .coreRxIsPec,
    .corePecValue, .coreTxNeed, .coreTxFirst, .coreStartDone,
    .coreReloadPause, .coreTransferDone, .coreNackSeen, .coreAddrMatch,
    .stopMode, .kernelOnInternalOsc, .debugHalt, .debugTimeoutFreeze, .txByte,
    .txByteValid, .nackRequest, .releaseBus, .toSlaveMode, .stopRequest, .startRequest,
    .addrRecognize, .wakeupRequest, .txDmaReq, .rxDmaReq, .eventIrq, .errorIrq);
  i2ce_bus_model i2ce_bus_model_inst (.scl(sclPin), .sda(sdaPin), .alertLine(alertLinePin));

  task chk(input [31:0] seen, input [31:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
    end
  endtask

  // one avalon access, held until waitrequest is seen low
  task bus(input rd, input [4:0] a, input [31:0] d);
    begin
      avsAddress <= a;
      avsRead <= rd;
      avsWrite <= !rd;
      avsWritedata <= d;
      @(posedge clk);
      while (avsWaitrequest !== 1'b0) @(posedge clk);
      rdata = avsReaddata;
      avsRead <= 1'b0;
      avsWrite <= 1'b0;
      repeat (2) @(posedge clk);
    end
  endtask

  // waits out the pin synchroniser and flag registers
  task settle;
    repeat (6) @(posedge clk);
  endtask

  task rx(input [7:0] b, input pec);
    begin
      coreRxByte <= b;
      coreRxIsPec <= pec;
      coreRxValid <= 1'b1;
      @(posedge clk);
      coreRxValid <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask

  task txNeed;
    begin
      coreTxNeed <= 1'b1;
      @(posedge clk);
      coreTxNeed <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask

  task stat(input integer bitPos, input exp);
    begin
      bus(1'b1, `I2CE_OFF_STATUS, 32'h0);
      chk(rdata[bitPos], exp);
      bus(1'b0, `I2CE_OFF_CLEAR, 32'h1 << bitPos);
    end
  endtask

  task t_regs;
    begin
      bus(1'b1, `I2CE_OFF_CTRL, 32'h0);
      chk(rdata, 32'h0);
      bus(1'b0, `I2CE_OFF_STATUS, 32'hffffffff);
      bus(1'b1, `I2CE_OFF_STATUS, 32'h0);
      chk(rdata, 32'h1 << `I2CE_F_TXE);
      bus(1'b1, `I2CE_OFF_PEC, 32'h0);
      chk(rdata, 32'h3c);
      bus(1'b0, 5'h1e, 32'h12345678);
      bus(1'b1, 5'h1e, 32'h0);
      chk(rdata, 32'h0);
    end
  endtask

  task t_rx;
    begin
      // receive request and interrupt enables set before any traffic
      bus(1'b0, `I2CE_OFF_CTRL, 32'h0cb);
      rx(8'ha5, 1'b0);
      chk(rxDmaReq, 1'b1);
      chk(eventIrq, 1'b1);
      rx(8'h5c, 1'b0);
      chk(nNack, 1);
      chk(errorIrq, 1'b1);
      bus(1'b1, `I2CE_OFF_RXDATA, 32'h0);
      chk(rdata, 32'ha5);
      chk(rxDmaReq, 1'b0);
      chk(eventIrq, 1'b0);
      stat(`I2CE_F_OVR, 1'b1);
      chk(errorIrq, 1'b0);
      bus(1'b0, `I2CE_OFF_CTRL, 32'h043);
      rx(8'h3d, 1'b1);
      chk(nNack, 2);
      chk(rxDmaReq, 1'b1);
      stat(`I2CE_F_PEC, 1'b1);
      bus(1'b1, `I2CE_OFF_RXDATA, 32'h0);
      chk(rdata, 32'h3d);
    end
  endtask

  task t_tx;
    begin
      bus(1'b0, `I2CE_OFF_CTRL, 32'h0a3);
      txNeed;
      chk(txByte, `I2CE_FILL_BYTE);
      chk(txDmaReq, 1'b1);
      stat(`I2CE_F_OVR, 1'b1);
      bus(1'b0, `I2CE_OFF_TXDATA, 32'h5a);
      chk(txDmaReq, 1'b0);
      txNeed;
      chk(txByte, 8'h5a);
      stat(`I2CE_F_OVR, 1'b0);
    end
  endtask

  task t_misplaced;
    begin
      bus(1'b0, `I2CE_OFF_CTRL, 32'h003);
      // addressed, but still in the address phase
      coreSlaveAddressed <= 1'b1;
      coreAddrPhase <= 1'b1;
      i2ce_bus_model_inst.cond(1'b0);
      i2ce_bus_model_inst.pulses(3, 1'b1);
      i2ce_bus_model_inst.cond(1'b0);
      i2ce_bus_model_inst.pulses(3, 1'b0);
      i2ce_bus_model_inst.cond(1'b1);
      settle;
      stat(`I2CE_F_MISPLACED_CONDITION_FLAG, 1'b0);
      chk(nAddr, 2);
      coreAddrPhase <= 1'b0;
      i2ce_bus_model_inst.cond(1'b0);
      i2ce_bus_model_inst.pulses(9, 1'b0);
      i2ce_bus_model_inst.cond(1'b1);
      settle;
      stat(`I2CE_F_MISPLACED_CONDITION_FLAG, 1'b0);
      i2ce_bus_model_inst.cond(1'b0);
      i2ce_bus_model_inst.pulses(3, 1'b1);
      i2ce_bus_model_inst.cond(1'b0);
      settle;
      chk(errorIrq, 1'b1);
      stat(`I2CE_F_MISPLACED_CONDITION_FLAG, 1'b1);
      chk(nAddr, 5);
      coreSlaveAddressed <= 1'b0;
      i2ce_bus_model_inst.pulses(9, 1'b0);
      i2ce_bus_model_inst.cond(1'b1);
      settle;
    end
  endtask

  task t_arb;
    begin
      coreMaster <= 1'b1;
      coreReloadPause <= 1'b1;
      coreTransferDone <= 1'b1;
      coreNackSeen <= 1'b1;
      @(posedge clk);
      coreReloadPause <= 1'b0;
      coreTransferDone <= 1'b0;
      coreNackSeen <= 1'b0;
      bus(1'b0, `I2CE_OFF_CTRL2, 32'h100);
      chk(startRequest, 1'b1);
      bus(1'b1, `I2CE_OFF_STATUS, 32'h0);
      chk(rdata[5:3], 3'b101);
      coreStartDone <= 1'b1;
      @(posedge clk);
      coreStartDone <= 1'b0;
      bus(1'b0, `I2CE_OFF_CTRL2, 32'h101);
      coreSdaReleased <= 1'b1;
      i2ce_bus_model_inst.cond(1'b0);
      i2ce_bus_model_inst.pulses(1, 1'b0);
      settle;
      chk(startRequest, 1'b0);
      chk(nRel, 1);
      stat(`I2CE_F_ARB, 1'b1);
      stat(`I2CE_F_RELOAD, 1'b0);
      coreMaster <= 1'b0;
      coreSdaReleased <= 1'b0;
      i2ce_bus_model_inst.pulses(8, 1'b0);
      i2ce_bus_model_inst.cond(1'b1);
      settle;
      // first byte after a stop with the register loaded
      bus(1'b0, `I2CE_OFF_CTRL, 32'h083);
      bus(1'b0, `I2CE_OFF_TXDATA, 32'h77);
      coreTxFirst <= 1'b1;
      txNeed;
      coreTxFirst <= 1'b0;
      chk(txByte, 8'h77);
      stat(`I2CE_F_OVR, 1'b1);
    end
  endtask

  task t_timeout;
    begin
      coreMaster <= 1'b1;
      debugHalt <= 1'b1;
      debugTimeoutFreeze <= 1'b1;
      bus(1'b0, `I2CE_OFF_TIMEOUT, 32'h8003);
      i2ce_bus_model_inst.lowFor(2000);
      settle;
      chk(errorIrq, 1'b0);
      debugTimeoutFreeze <= 1'b0;
      i2ce_bus_model_inst.lowFor(2000);
      settle;
      chk(errorIrq, 1'b1);
      chk(stopRequest, 1'b1);
      stat(`I2CE_F_TIMEOUT, 1'b1);
      coreMaster <= 1'b0;
      coreSlaveAddressed <= 1'b1;
      i2ce_bus_model_inst.lowFor(2000);
      settle;
      chk(nRel, 2);
      bus(1'b0, `I2CE_OFF_TIMEOUT, 32'h80030000);
      stat(`I2CE_F_TIMEOUT, 1'b1);
      // cumulative stretch of three ticks
      coreStretching <= 1'b1;
      repeat (60) @(posedge clk);
      coreStretching <= 1'b0;
      stat(`I2CE_F_TIMEOUT, 1'b1);
      chk(nRel, 3);
      coreSlaveAddressed <= 1'b0;
    end
  endtask

  task t_alert_wake;
    begin
      for (h = 0; h < 2; h = h + 1) begin
        bus(1'b0, `I2CE_OFF_CTRL, 32'h403 | (h << 9));
        i2ce_bus_model_inst.alert;
        settle;
        stat(`I2CE_F_ALERT, h);
      end
      bus(1'b0, `I2CE_OFF_CTRL, 32'h801);
      stopMode <= 1'b1;
      for (h = 0; h < 2; h = h + 1) begin
        kernelOnInternalOsc <= h;
        coreAddrMatch <= 1'b1;
        @(posedge clk);
        coreAddrMatch <= 1'b0;
        settle;
        chk(nWake, h);
      end
    end
  endtask

  task report_and_stop;
    begin
      $display("comparisons %0d, mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask

  // watchdog: the whole sequence needs well under this span
  initial begin
    #500000;
    n_errors = n_errors + 1;
    report_and_stop;
  end

  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    t_regs;
    t_rx;
    t_tx;
    t_misplaced;
    t_arb;
    t_timeout;
    t_alert_wake;
    report_and_stop;
  end
endmodule // i2ce_err_top_tb
